// file: hdl/sac_adc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "sac_map.svh"
module sac_adc_ctrl
  import sac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rc_clk_tick,
  input wire logic sleep_mode,
  input wire logic comp_above,
  input wire logic [3:0] port_pin_level,
  output logic [1:0] analog_channel,
  output logic ref_from_pin,
  output logic sample_switch_open,
  output logic [7:0] dac_trial,
  output logic converter_power_on,
  output logic [3:0] pin_analog_mode,
  output logic conv_done
);

  ////////////////////////////////////////////////////////////////////////
  // registers and state
  logic [7:0] converter_control0;
  logic [7:0] pin_function_config;
  logic [7:0] conversion_result_reg;
  logic ref_select;
  sac_state_t state;
  logic [4:0] half_cnt;
  logic [4:0] div_cnt;
  logic tad_edge;
  logic [7:0] trial;
  logic [3:0] bit_idx;
  logic [2:0] rc_sync;
  logic rc_level;
  logic rc_tick;
  logic [2:0] pin_sync [0:3];
  logic [3:0] pin_level;
  logic cmp_level;
  logic next_switch_open;

  logic apb_wr;
  logic apb_rd;
  logic start_req;
  logic finish;
  sac_clk_sel_t clk_sel;
  logic [4:0] div_half;

  assign apb_wr = psel && penable && pwrite && pready;
  assign apb_rd = psel && penable && !pwrite && pready;
  assign clk_sel = sac_clk_sel_t'(converter_control0[`SAC_CLK_HI:`SAC_CLK_LO]);
  assign start_req = apb_wr && paddr == `SAC_ADDR_CTRL0 &&
    pwdata[`SAC_GO_BIT] && pwdata[`SAC_ON_BIT];
  assign finish = state == SAC_CONV && tad_edge &&
    half_cnt == `SAC_HALF_PERIODS - 5'd1;

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers: three stages, change taken when stages 2 and 3 agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_sync <= 3'h0;
      rc_level <= 1'b0;
    end else begin
      rc_sync <= {rc_sync[1:0], rc_clk_tick};
      if (rc_sync[1] == rc_sync[2]) begin
        rc_level <= rc_sync[2];
      end
    end
  end

  // comparator runs on pclk and settles a cycle after dac_trial moves;
  // three stages here would outlast a /2 conversion period
  assign cmp_level = comp_above;

  // one edge of the rc clock gives one half period
  assign rc_tick = (rc_sync[1] == rc_sync[2]) && (rc_sync[2] != rc_level);

  // port pin synchronisers, all four pins in one process (single driver)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        pin_sync[i] <= 3'h0;
      end
      pin_level <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        pin_sync[i] <= {pin_sync[i][1:0], port_pin_level[i]};
        if (pin_sync[i][1] == pin_sync[i][2]) begin
          pin_level[i] <= pin_sync[i][2];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, unmapped offsets answer with an error
  // ready from a flop, high in and out of reset: every access is one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b1;
    end else begin
      pready <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
      if (psel && !penable) begin
        pslverr <= !(paddr == `SAC_ADDR_CTRL0 || paddr == `SAC_ADDR_PINCFG ||
          paddr == `SAC_ADDR_RESULT || paddr == `SAC_ADDR_PORTRD ||
          paddr == `SAC_ADDR_REFSEL);
        case (paddr)
          `SAC_ADDR_CTRL0: prdata <= {24'h0, converter_control0};
          `SAC_ADDR_PINCFG: prdata <= {24'h0, pin_function_config};
          `SAC_ADDR_RESULT: prdata <= {24'h0, conversion_result_reg};
          `SAC_ADDR_PORTRD: prdata <= {28'h0, pin_level & ~pin_analog_mode};
          `SAC_ADDR_REFSEL: prdata <= {31'h0, ref_select};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register; start flag set by software, cleared by hardware
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_control0 <= `SAC_CTRL0_RST;
    end else begin
      if (apb_wr && paddr == `SAC_ADDR_CTRL0) begin
        converter_control0[7:3] <= pwdata[7:3];
        converter_control0[`SAC_ON_BIT] <= pwdata[`SAC_ON_BIT];
        converter_control0[1] <= 1'b0;
      end
      if (start_req) begin
        converter_control0[`SAC_GO_BIT] <= 1'b1;
      end else if (finish) begin
        converter_control0[`SAC_GO_BIT] <= 1'b0;
      end else if (!converter_control0[`SAC_ON_BIT] ||
          (apb_wr && paddr == `SAC_ADDR_CTRL0 && !pwdata[`SAC_ON_BIT])) begin
        converter_control0[`SAC_GO_BIT] <= 1'b0;
      end
    end
  end

  // pin function and reference configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_function_config <= `SAC_PINCFG_RST;
      ref_select <= 1'b0;
    end else begin
      if (apb_wr && paddr == `SAC_ADDR_PINCFG) begin
        pin_function_config <= pwdata[7:0];
      end
      if (apb_wr && paddr == `SAC_ADDR_REFSEL) begin
        ref_select <= pwdata[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion clock: divider or rc edges; stopped while powered off
  always_comb begin
    case (clk_sel)
      SAC_DIV2: div_half = `SAC_DIV2_HALF;
      SAC_DIV8: div_half = `SAC_DIV8_HALF;
      SAC_DIV32: div_half = `SAC_DIV32_HALF;
      default: div_half = 5'd1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 5'h0;
      tad_edge <= 1'b0;
    end else if (!converter_control0[`SAC_ON_BIT] || state != SAC_CONV) begin
      div_cnt <= 5'h0;
      tad_edge <= 1'b0;
    end else if (clk_sel == SAC_RC) begin
      tad_edge <= rc_tick;
      div_cnt <= 5'h0;
    end else if (sleep_mode) begin
      tad_edge <= 1'b0;
    end else if (div_cnt == div_half - 5'd1) begin
      div_cnt <= 5'h0;
      tad_edge <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 5'd1;
      tad_edge <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // successive approximation sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SAC_IDLE;
      half_cnt <= 5'h0;
      trial <= 8'h0;
      bit_idx <= 4'h0;
      conversion_result_reg <= 8'h0;
      conv_done <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      case (state)
        SAC_IDLE: begin
          if (start_req) begin
            state <= SAC_CONV;
            half_cnt <= 5'h0;
            trial <= 8'h80;
            bit_idx <= 4'd7;
          end
        end
        SAC_CONV: begin
          if (!converter_control0[`SAC_ON_BIT]) begin
            state <= SAC_IDLE;
          end else if (finish) begin
            state <= SAC_IDLE;
            conversion_result_reg <= trial;
            conv_done <= 1'b1;
          end else if (tad_edge) begin
            half_cnt <= half_cnt + 5'd1;
            // one bit resolved at the end of each of the first eight full periods
            if (half_cnt[0] && half_cnt < 5'd16) begin
              trial[bit_idx[2:0]] <= cmp_level;
              if (bit_idx != 4'd0) begin
                trial[bit_idx[2:0] - 3'd1] <= 1'b1;
              end
              bit_idx <= bit_idx - 4'd1;
            end
          end
        end
        default: state <= SAC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // analog front end controls, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_channel <= 2'h0;
      ref_from_pin <= 1'b0;
      sample_switch_open <= 1'b0;
      dac_trial <= 8'h0;
      converter_power_on <= 1'b0;
      pin_analog_mode <= 4'h0;
    end else begin
      analog_channel <= converter_control0[4:3];
      ref_from_pin <= ref_select;
      sample_switch_open <= next_switch_open;
      dac_trial <= trial;
      converter_power_on <= converter_control0[`SAC_ON_BIT];
      pin_analog_mode <= pin_function_config[3:0];
    end
  end

  assign next_switch_open = (state == SAC_CONV && !finish) || start_req;

  ////////////////////////////////////////////////////////////////////////
  // checks
  // a restart in the completion cycle keeps the flag set
  a_done_clears_go: assert property (
    @(posedge pclk) disable iff (!presetn)
    finish && converter_control0[`SAC_ON_BIT] && !start_req
    |=> !converter_control0[`SAC_GO_BIT] && conv_done)
    else $error("start flag not cleared at completion");
  a_result_loaded: assert property (
    @(posedge pclk) disable iff (!presetn)
    finish && converter_control0[`SAC_ON_BIT]
    |=> conversion_result_reg == $past(trial))
    else $error("result not loaded at completion");
  a_bit1_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    converter_control0[1] == 1'b0)
    else $error("unimplemented bit reads one");
  // a start written together with power-on is allowed to begin
  a_off_no_conv: assert property (
    @(posedge pclk) disable iff (!presetn)
    !converter_control0[`SAC_ON_BIT] && !start_req |=> state == SAC_IDLE)
    else $error("conversion while powered off");
  a_go_while_busy: assert property (
    @(posedge pclk) disable iff (!presetn)
    state == SAC_CONV && converter_control0[`SAC_ON_BIT] && !finish
    |-> converter_control0[`SAC_GO_BIT])
    else $error("flag low during conversion");
  a_switch_open: assert property (
    @(posedge pclk) disable iff (!presetn)
    state == SAC_CONV && $past(state) == SAC_CONV |-> sample_switch_open)
    else $error("sampling switch closed mid conversion");
  a_port_analog_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    apb_rd && paddr == `SAC_ADDR_PORTRD |->
    (prdata[3:0] & pin_analog_mode) == 4'h0)
    else $error("analog pin reads nonzero");
  a_no_clk_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    !converter_control0[`SAC_ON_BIT] |=> !tad_edge)
    else $error("conversion clock runs while off");
  // all eight bits must be resolved by the last half period
  a_length: assert property (
    @(posedge pclk) disable iff (!presetn)
    finish |-> bit_idx == 4'hf)
    else $error("conversion ended before all bits resolved");
  a_power_follow: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> converter_power_on == $past(converter_control0[0]))
    else $error("power output does not follow control bit");

endmodule
`default_nettype wire

// file: hdl/sac_map.svh
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
// register offsets (byte addresses; printed index times four)
`define SAC_IDX_CTRL0 8'h1f
`define SAC_ADDR_CTRL0 12'h07c
`define SAC_ADDR_PINCFG 12'h080
`define SAC_ADDR_RESULT 12'h084
`define SAC_ADDR_PORTRD 12'h088
`define SAC_ADDR_REFSEL 12'h08c
// control register fields
`define SAC_CLK_HI 7
`define SAC_CLK_LO 6
`define SAC_CHS_HI 5
`define SAC_CHS_LO 3
`define SAC_GO_BIT 2
`define SAC_ON_BIT 0
// reset values
`define SAC_CTRL0_RST 8'h00
`define SAC_PINCFG_RST 8'h00
// timing: half periods of the conversion clock per conversion (9.5 periods)
`define SAC_HALF_PERIODS 5'd19
// divider half periods in pclk cycles for /2, /8, /32
`define SAC_DIV2_HALF 5'd1
`define SAC_DIV8_HALF 5'd4
`define SAC_DIV32_HALF 5'd16
`endif

// file: hdl/sac_pkg.sv
package sac_pkg;
  typedef enum logic [1:0] {
    SAC_DIV2,
    SAC_DIV8,
    SAC_DIV32,
    SAC_RC
  } sac_clk_sel_t;
  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_CONV
  } sac_state_t;
endpackage

// file: bench/sac_analog_model.sv
`timescale 1ns/1ns
`default_nettype none
// analog side: input pins, holding capacitor, comparator and rc oscillator
module sac_analog_model (
  input wire logic pclk,
  input wire logic [1:0] analog_channel,
  input wire logic sample_switch_open,
  input wire logic [7:0] dac_trial,
  input wire logic [31:0] chan_levels,
  output logic comp_above,
  output logic rc_clk_tick
);
  logic [7:0] held;
  logic noise;
  initial begin
    rc_clk_tick = 1'b0;
    held = 8'h00;
    noise = 1'b0;
  end
  // free-running rc oscillator, phase unrelated to pclk
  always #23 rc_clk_tick = ~rc_clk_tick;
  // capacitor tracks the selected pin until the switch opens
  always @(posedge pclk) begin
    if (!sample_switch_open) begin
      held <= chan_levels[analog_channel*8 +: 8];
    end
    noise <= ~noise;
  end
  // level sits half a step above its code; comparator is junk when idle
  assign comp_above = sample_switch_open ?
    ({held, 1'b1} > {dac_trial, 1'b0}) : noise;
endmodule
`default_nettype wire

// file: bench/sac_adc_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "sac_map.svh"
module sac_adc_ctrl_tb
  import sac_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic sleep_mode = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] chan_levels = 32'h815aff00;
  logic [3:0] port_pin_level = 4'hf;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, rc_clk_tick, comp_above;
  logic [1:0] analog_channel;
  logic ref_from_pin, sample_switch_open, converter_power_on, conv_done;
  logic [7:0] dac_trial;
  logic [3:0] pin_analog_mode;
  int fails = 0;
  int num_checks = 0;
  int n;
  always #5 pclk = ~pclk;
  sac_adc_ctrl i_sac_adc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rc_clk_tick(rc_clk_tick), .sleep_mode(sleep_mode),
    .comp_above(comp_above), .port_pin_level(port_pin_level),
    .analog_channel(analog_channel), .ref_from_pin(ref_from_pin),
    .sample_switch_open(sample_switch_open), .dac_trial(dac_trial),
    .converter_power_on(converter_power_on),
    .pin_analog_mode(pin_analog_mode), .conv_done(conv_done));
  sac_analog_model i_sac_analog_model (.pclk(pclk),
    .analog_channel(analog_channel), .sample_switch_open(sample_switch_open),
    .dac_trial(dac_trial), .chan_levels(chan_levels),
    .comp_above(comp_above), .rc_clk_tick(rc_clk_tick));
  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one apb transfer: setup, access until pready, then release
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // wait for the completion pulse, counting edges
  task wait_done;
    while (conv_done !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, conv_done}, 32'h1);
  endtask
  // one conversion; the pin level moves once the switch is open
  task conv(input sac_clk_sel_t sel, input logic [1:0] ch,
            input logic [7:0] exp);
    int h;
    h = (sel == SAC_DIV2) ? 1 : (sel == SAC_DIV8) ? 4 : 16;
    apb(1'b1, `SAC_ADDR_CTRL0, {24'h0, sel, 1'b0, ch, 3'b001});
    repeat (8) @(posedge pclk);
    apb(1'b1, `SAC_ADDR_CTRL0, {24'h0, sel, 1'b0, ch, 3'b101});
    repeat (3) @(posedge pclk);
    chk({31'h0, sample_switch_open}, 32'h1);
    chan_levels <= ~chan_levels;
    n = 3;
    wait_done;
    if (sel != SAC_RC && sleep_mode == 1'b0) begin
      chk({31'h0, n >= 19 * h && n <= 19 * h + 4}, 32'h1);
    end
    chan_levels <= ~chan_levels;
    apb(1'b0, `SAC_ADDR_RESULT, 32'h0);
    chk(rd, {24'h0, exp});
    apb(1'b0, `SAC_ADDR_CTRL0, 32'h0);
    chk(rd, {24'h0, sel, 1'b0, ch, 3'b001});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    fails++;
    tally_and_finish;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SAC_ADDR_CTRL0, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, `SAC_ADDR_CTRL0, 32'hfa);
    apb(1'b0, `SAC_ADDR_CTRL0, 32'h0);
    chk(rd, 32'hf8);
    chk({30'h0, analog_channel}, 32'h3);
    apb(1'b1, `SAC_ADDR_CTRL0, 32'h04);
    apb(1'b0, `SAC_ADDR_CTRL0, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, sample_switch_open}, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      conv(sac_clk_sel_t'(i), i[1:0], chan_levels[i*8 +: 8]);
    end
    $display("test conversions done");
    sleep_mode <= 1'b1;
    conv(SAC_RC, 2'd2, 8'h5a);
    apb(1'b1, `SAC_ADDR_CTRL0, 32'h05);
    repeat (60) @(posedge pclk);
    apb(1'b0, `SAC_ADDR_CTRL0, 32'h0);
    chk(rd, 32'h05);
    sleep_mode <= 1'b0;
    n = 0;
    wait_done;
    $display("test sleep done");
    apb(1'b1, `SAC_ADDR_CTRL0, 32'h85);
    repeat (20) @(posedge pclk);
    apb(1'b1, `SAC_ADDR_CTRL0, 32'h80);
    apb(1'b0, `SAC_ADDR_CTRL0, 32'h0);
    chk(rd, 32'h80);
    chk({30'h0, converter_power_on, sample_switch_open}, 32'h0);
    apb(1'b1, `SAC_ADDR_CTRL0, 32'h85);
    repeat (20) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SAC_ADDR_CTRL0, 32'h0);
    chk(rd, 32'h0);
    $display("test abort done");
    apb(1'b1, `SAC_ADDR_PINCFG, 32'h05);
    apb(1'b0, `SAC_ADDR_PORTRD, 32'h0);
    chk(rd, 32'h0a);
    chk({28'h0, pin_analog_mode}, 32'h5);
    apb(1'b1, `SAC_ADDR_REFSEL, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, ref_from_pin}, 32'h1);
    $display("test pins done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
